// File: logic/urxg_top.sv
// Receive command generator facing the link side of the data bus
`timescale 1ns/100ps
`include "urxg_params.svh"
module urxg_top (
   input wire logic clk, // System clock, 125 MHz
   input wire logic nrst, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   output logic irq, // Interrupt, level
   input wire logic link_clk, // Link bus clock
   input wire logic stp, // Stop from the link
   input wire logic dp, // Plus line receiver
   input wire logic dm, // Minus line receiver
   input wire logic id_pin, // Identity pin level
   input wire logic sess_end, // Session end comparator
   input wire logic sess_vld, // Session valid comparator
   input wire logic vbus_vld, // Bus valid comparator
   output logic dir, // Bus direction, high while we own it
   output logic nxt, // Next byte strobe
   output logic [7:0] data_o, // Bus data out
   output logic data_oe, // Bus data output enable
   input wire logic phy_ready, // Start-up complete
   input wire logic lp_exit, // Leaving low power or serial modes
   input wire logic tx_active, // Link transmit in progress
   input wire logic rx_active, // Receive in progress
   input wire logic rx_error, // Receive error
   input wire logic host_disc, // Host disconnect detected
   input wire logic rx_valid, // Received byte waiting
   input wire logic [7:0] rx_data, // Received byte
   output logic rx_take, // Received byte consumed
   input wire logic [3:0] acc_event // Accessory interrupt sources
);
   urxg_pkg::urxg_pins_t pins_raw;
   urxg_pkg::urxg_pins_t pins_s;
   urxg_pkg::urxg_state_t st_r;
   urxg_pkg::urxg_rxcmd_t cmd_now;
   logic lk_prev_r;
   logic lk_rise;
   logic [1:0] ls_prev_r;
   logic [3:0] cmp_prev_r;
   logic ls_chg;
   logic cmp_chg;
   logic pend_r;
   logic pend_set;
   logic pend_clr;
   logic tx_stp_r;
   logic tx_prev_r;
   logic tx_done;
   logic tx_hold;
   logic sync_mode;
   logic alt_any;
   logic sent_ev_r;
   logic [2:0] events;

   assign pins_raw = '{link_clk: link_clk, stp: stp, id: id_pin,
      sess_end: sess_end, sess_vld: sess_vld, vbus_vld: vbus_vld,
      dm: dm, dp: dp};

   urxg_sync u_sync (
      .clk(clk),
      .nrst(nrst),
      .pins_i(pins_raw),
      .pins_o(pins_s)
   );

   assign events = {rx_error && rx_active, cmp_chg, sent_ev_r};

   urxg_regs u_regs (
      .clk(clk),
      .nrst(nrst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .event_i(events),
      .acc_event_i(acc_event),
      .stat_i({3'h0, pend_r, dir, st_r, cmd_now}),
      .sync_mode(sync_mode),
      .alt_any(alt_any),
      .irq(irq)
   );

   function automatic logic [1:0] vbus_code(input logic s_end,
      input logic s_vld, input logic b_vld);
      if (b_vld)
         vbus_code = `URXG_VBUS_ABOVE_VLD;
      else if (s_vld)
         vbus_code = `URXG_VBUS_SESS_TO_VLD;
      else if (s_end)
         vbus_code = `URXG_VBUS_BELOW_END;
      else
         vbus_code = `URXG_VBUS_END_TO_SESS;
   endfunction

   function automatic logic [1:0] rx_code(input logic act,
      input logic err, input logic disc);
      if (disc)
         rx_code = `URXG_RXEV_DISC;
      else if (act && err)
         rx_code = `URXG_RXEV_ERROR;
      else if (act)
         rx_code = `URXG_RXEV_ACTIVE;
      else
         rx_code = `URXG_RXEV_NONE;
   endfunction

   // Built from live state at load time, so no stale copy is sent
   always_comb begin
      cmd_now.alt_int = alt_any;
      cmd_now.id = pins_s.id;
      cmd_now.rx_event = rx_code(rx_active, rx_error, host_disc);
      cmd_now.vbus = vbus_code(pins_s.sess_end, pins_s.sess_vld,
         pins_s.vbus_vld);
      cmd_now.line = {pins_s.dm, pins_s.dp};
   end

   assign lk_rise = pins_s.link_clk && !lk_prev_r;
   assign ls_chg = ({pins_s.dm, pins_s.dp} != ls_prev_r);
   assign cmp_chg = ({pins_s.id, pins_s.sess_end, pins_s.sess_vld,
      pins_s.vbus_vld} != cmp_prev_r);
   assign tx_hold = tx_active && !tx_stp_r;
   assign tx_done = tx_prev_r && !tx_active && tx_stp_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lk_prev_r <= 1'b0;
         ls_prev_r <= 2'h0;
         cmp_prev_r <= 4'h0;
         tx_prev_r <= 1'b0;
      end else begin
         lk_prev_r <= pins_s.link_clk;
         ls_prev_r <= {pins_s.dm, pins_s.dp};
         cmp_prev_r <= {pins_s.id, pins_s.sess_end, pins_s.sess_vld,
            pins_s.vbus_vld};
         tx_prev_r <= tx_active;
      end
   end

   // Stop seen during a transmit, held until the transmit ends
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         tx_stp_r <= 1'b0;
      else if (!tx_active)
         tx_stp_r <= 1'b0;
      else if (pins_s.stp)
         tx_stp_r <= 1'b1;
   end

   // A command goes out whenever the bus next carries one
   assign pend_clr = lk_rise && (st_r == urxg_pkg::ST_TURN_UP ||
      (st_r == urxg_pkg::ST_RX && !rx_valid));
   always_comb begin
      pend_set = 1'b0;
      if (ls_chg && !tx_hold)
         pend_set = 1'b1;
      if (cmp_chg)
         pend_set = 1'b1;
      if (tx_done)
         pend_set = 1'b1;
      if (lp_exit && pins_s.stp)
         pend_set = 1'b1;
      if (st_r == urxg_pkg::ST_START && lk_rise && phy_ready &&
         !pins_s.stp)
         pend_set = 1'b1;
   end

   // Set wins over the clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         pend_r <= 1'b0;
      else
         pend_r <= pend_set || (pend_r && !pend_clr);
   end

   // Bus sequencer, advances once per link clock rise
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= urxg_pkg::ST_START;
         dir <= 1'b1;
         nxt <= 1'b0;
         data_oe <= 1'b0;
         data_o <= 8'h00;
         rx_take <= 1'b0;
         sent_ev_r <= 1'b0;
      end else begin
         rx_take <= 1'b0;
         sent_ev_r <= 1'b0;
         if (lk_rise) begin
            case (st_r)
               urxg_pkg::ST_START: begin
                  if (phy_ready) begin
                     st_r <= urxg_pkg::ST_TURN_DN;
                     dir <= 1'b0;
                  end
               end
               urxg_pkg::ST_IDLE: begin
                  if (sync_mode && rx_active && !tx_active) begin
                     st_r <= urxg_pkg::ST_RX;
                     dir <= 1'b1;
                     nxt <= 1'b1;
                  end else if (sync_mode && pend_r && !tx_hold) begin
                     st_r <= urxg_pkg::ST_TURN_UP;
                     dir <= 1'b1;
                  end
               end
               urxg_pkg::ST_TURN_UP: begin
                  st_r <= urxg_pkg::ST_CMD;
                  data_oe <= 1'b1;
                  data_o <= cmd_now;
                  sent_ev_r <= 1'b1;
               end
               urxg_pkg::ST_CMD: begin
                  if (rx_active && sync_mode) begin
                     st_r <= urxg_pkg::ST_RX;
                     nxt <= rx_valid;
                     data_o <= rx_valid ? rx_data : cmd_now;
                     rx_take <= rx_valid;
                     sent_ev_r <= !rx_valid;
                  end else begin
                     st_r <= urxg_pkg::ST_TURN_DN;
                     dir <= 1'b0;
                     data_oe <= 1'b0;
                  end
               end
               urxg_pkg::ST_RX: begin
                  data_oe <= 1'b1;
                  if (rx_valid) begin
                     nxt <= 1'b1;
                     data_o <= rx_data;
                     rx_take <= 1'b1;
                  end else begin
                     nxt <= 1'b0;
                     data_o <= cmd_now;
                     sent_ev_r <= 1'b1;
                     if (!rx_active)
                        st_r <= urxg_pkg::ST_CMD;
                  end
               end
               urxg_pkg::ST_TURN_DN: begin
                  st_r <= urxg_pkg::ST_IDLE;
               end
               default: begin
                  st_r <= urxg_pkg::ST_IDLE;
                  dir <= 1'b0;
                  nxt <= 1'b0;
                  data_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   a_oe_needs_dir: assert property (@(posedge clk) disable iff (!nrst)
      data_oe |-> dir) else $error("bus driven with direction low");
   a_turn_up_quiet: assert property (@(posedge clk) disable iff (!nrst)
      $rose(dir) |-> !data_oe) else $error("no turnaround on rise");
   a_turn_dn_quiet: assert property (@(posedge clk) disable iff (!nrst)
      $fell(dir) |-> !data_oe) else $error("driving after fall");
   a_line_bits: assert property (@(posedge clk) disable iff (!nrst)
      $rose(data_oe) && !nxt |-> data_o[1:0] == $past(cmd_now.line))
      else $error("line state bits wrong");
   a_vbus_bits: assert property (@(posedge clk) disable iff (!nrst)
      $rose(data_oe) && !nxt |-> data_o[3:2] == vbus_code(
      $past(pins_s.sess_end), $past(pins_s.sess_vld),
      $past(pins_s.vbus_vld))) else $error("bus voltage code wrong");
   a_rx_bits: assert property (@(posedge clk) disable iff (!nrst)
      $rose(data_oe) && !nxt |-> data_o[5:4] == rx_code($past(rx_active),
      $past(rx_error), $past(host_disc))) else $error("event code");
   a_id_alt_bits: assert property (@(posedge clk) disable iff (!nrst)
      $rose(data_oe) && !nxt |-> data_o[7:6] == {$past(alt_any),
      $past(pins_s.id)}) else $error("id or alt bit wrong");
   a_rx_cmd_slot: assert property (@(posedge clk) disable iff (!nrst)
      lk_rise && st_r == urxg_pkg::ST_RX && !rx_valid |=> data_oe && !nxt
      && data_o == $past(cmd_now)) else $error("no command in slot");
   a_rx_start: assert property (@(posedge clk) disable iff (!nrst)
      lk_rise && st_r == urxg_pkg::ST_IDLE && sync_mode && rx_active &&
      !tx_active |=> dir && nxt && !data_oe)
      else $error("receive start not signalled");
   a_take_bus: assert property (@(posedge clk) disable iff (!nrst)
      lk_rise && st_r == urxg_pkg::ST_IDLE && sync_mode && pend_r &&
      !tx_active && !rx_active |=> dir && st_r == urxg_pkg::ST_TURN_UP)
      else $error("pending command did not take bus");
   a_tx_hold_off: assert property (@(posedge clk) disable iff (!nrst)
      tx_active && !tx_stp_r && !dir |=> !dir)
      else $error("bus taken during transmit");
endmodule

// File: shared/urxg_params.svh
// Offsets, field positions, reset values and codes of the receive command logic
`ifndef URXG_PARAMS_SVH
`define URXG_PARAMS_SVH
`define URXG_OFF_CTRL 12'h000
`define URXG_OFF_STAT 12'h004
`define URXG_OFF_IRQ_STATUS 12'h008
`define URXG_OFF_IRQ_MASK 12'h00C
`define URXG_OFF_ALT_LATCH 12'h010
`define URXG_OFF_ALT_MASK 12'h014
`define URXG_CTRL_SYNC_BIT 0
`define URXG_CTRL_RST 32'h00000001
`define URXG_IRQ_MASK_RST 3'h0
`define URXG_ALT_MASK_RST 4'hF
`define URXG_EV_SENT_BIT 0
`define URXG_EV_CMP_BIT 1
`define URXG_EV_RXERR_BIT 2
`define URXG_VBUS_BELOW_END 2'h0
`define URXG_VBUS_END_TO_SESS 2'h1
`define URXG_VBUS_SESS_TO_VLD 2'h2
`define URXG_VBUS_ABOVE_VLD 2'h3
`define URXG_RXEV_NONE 2'h0
`define URXG_RXEV_ACTIVE 2'h1
`define URXG_RXEV_ERROR 2'h3
`define URXG_RXEV_DISC 2'h2
`endif

// File: shared/urxg_pkg.sv
// Types of the receive command logic
package urxg_pkg;
   typedef struct packed {
      logic alt_int;
      logic id;
      logic [1:0] rx_event;
      logic [1:0] vbus;
      logic [1:0] line;
   } urxg_rxcmd_t;
   typedef struct packed {
      logic link_clk;
      logic stp;
      logic id;
      logic sess_end;
      logic sess_vld;
      logic vbus_vld;
      logic dm;
      logic dp;
   } urxg_pins_t;
   typedef enum logic [2:0] {
      ST_START,
      ST_IDLE,
      ST_TURN_UP,
      ST_CMD,
      ST_RX,
      ST_TURN_DN
   } urxg_state_t;
endpackage

// File: logic/urxg_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module urxg_sync (
   input wire logic clk, // System clock
   input wire logic nrst, // Async reset, active low
   input wire urxg_pkg::urxg_pins_t pins_i, // Raw pins
   output urxg_pkg::urxg_pins_t pins_o // Synchronised pins
);
   urxg_pkg::urxg_pins_t meta_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '0;
         pins_o <= '0;
      end else begin
         meta_r <= pins_i;
         pins_o <= meta_r;
      end
   end
endmodule

// File: logic/urxg_regs.sv
// APB register file, interrupt status and accessory interrupt latch
`timescale 1ns/100ps
`include "urxg_params.svh"
module urxg_regs (
   input wire logic clk, // System clock
   input wire logic nrst, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic [2:0] event_i, // Block events, one-cycle pulses on bits 0 and 1, a level on bit 2
   input wire logic [3:0] acc_event_i, // Accessory interrupt sources
   input wire logic [15:0] stat_i, // Block state readback
   output logic sync_mode, // Synchronous mode enable
   output logic alt_any, // Unmasked accessory latch bit set
   output logic irq // Interrupt, level
);
   logic [31:0] ctrl_r;
   logic [2:0] irq_status_r;
   logic [2:0] irq_mask_r;
   logic [3:0] alt_latch_r;
   logic [3:0] alt_mask_r;
   logic setup;
   logic wr;
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && pready;
   assign sync_mode = ctrl_r[`URXG_CTRL_SYNC_BIT];
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r <= `URXG_CTRL_RST;
         irq_mask_r <= `URXG_IRQ_MASK_RST;
         alt_mask_r <= `URXG_ALT_MASK_RST;
      end else if (wr) begin
         if (hit(paddr, `URXG_OFF_CTRL))
            ctrl_r <= {31'h00000000, pwdata[`URXG_CTRL_SYNC_BIT]};
         if (hit(paddr, `URXG_OFF_IRQ_MASK))
            irq_mask_r <= pwdata[2:0];
         if (hit(paddr, `URXG_OFF_ALT_MASK))
            alt_mask_r <= pwdata[3:0];
      end
   end
   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_status_r <= 3'h0;
         alt_latch_r <= 4'h0;
      end else begin
         irq_status_r <= (irq_status_r & ~((wr && hit(paddr,
            `URXG_OFF_IRQ_STATUS)) ? pwdata[2:0] : 3'h0)) | event_i;
         alt_latch_r <= (alt_latch_r & ~((wr && hit(paddr,
            `URXG_OFF_ALT_LATCH)) ? pwdata[3:0] : 4'h0)) | acc_event_i;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
         alt_any <= 1'b0;
      end else begin
         irq <= |(irq_status_r & irq_mask_r);
         alt_any <= |(alt_latch_r & alt_mask_r);
      end
   end
   // Answer one cycle after setup: zero wait states in the access phase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (setup) begin
            case (paddr)
               `URXG_OFF_CTRL: prdata <= ctrl_r;
               `URXG_OFF_STAT: prdata <= {16'h0000, stat_i};
               `URXG_OFF_IRQ_STATUS: prdata <= {29'h00000000, irq_status_r};
               `URXG_OFF_IRQ_MASK: prdata <= {29'h00000000, irq_mask_r};
               `URXG_OFF_ALT_LATCH: prdata <= {28'h0000000, alt_latch_r};
               `URXG_OFF_ALT_MASK: prdata <= {28'h0000000, alt_mask_r};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule

// File: sim/urxg_link_model.sv
// Link-side model: bus clock, stop strobe, command and byte capture
`timescale 1ns/100ps
module urxg_link_model (
   output logic link_clk, // Bus clock, free running
   output logic stp, // Stop to the device
   input wire logic stp_req, // Bench request for stop
   input wire logic dir, // Device owns the bus
   input wire logic nxt, // Next strobe
   input wire logic [7:0] data_o, // Device bus data
   input wire logic data_oe, // Device drives the bus
   output logic [7:0] last_cmd, // Latest command byte
   output logic [7:0] last_byte, // Latest received byte
   output int cmd_cnt, // Commands captured
   output logic rx_start_seen, // Direction and next rose together
   output logic turn_bad // Bus driven in a turnaround cycle
);
   logic dir_q;
   initial begin
      {stp, turn_bad, rx_start_seen, last_cmd, last_byte} = '0;
      cmd_cnt = 0;
      dir_q = 1'b1;
      link_clk = 1'b0;
      forever #32 link_clk = ~link_clk;
   end
   // Everything sampled on the bus clock only, as a real link would
   always @(posedge link_clk) begin
      dir_q <= dir;
      stp <= stp_req;
      if (dir !== dir_q && data_oe !== 1'b0) turn_bad <= 1'b1;
      if (dir && !dir_q && nxt) rx_start_seen <= 1'b1;
      if (dir && data_oe && !nxt) begin
         last_cmd <= data_o;
         cmd_cnt <= cmd_cnt + 1;
      end
      if (dir && data_oe && nxt) last_byte <= data_o;
   end
endmodule

// File: sim/urxg_top_tb_top.sv
// Self-checking bench for the receive command generator
`timescale 1ns/100ps
module urxg_top_tb_top;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, b;
   logic link_clk, stp, stp_req, dp, dm, id_pin, sess_end, sess_vld;
   logic vbus_vld, dir, nxt, data_oe, phy_ready, lp_exit, tx_active;
   logic rx_active, rx_error, host_disc, rx_valid, rx_take;
   logic rx_start_seen, turn_bad;
   logic [7:0] data_o, rx_data, last_cmd, last_byte;
   logic [3:0] acc_event;
   logic [2:0] ev_tab [3] = '{3'h4, 3'h6, 3'h1};
   int cmd_cnt, miscompares, total_checks, cycles, seed, c0, i;

   urxg_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .link_clk(link_clk),
      .stp(stp), .dp(dp), .dm(dm), .id_pin(id_pin), .sess_end(sess_end),
      .sess_vld(sess_vld), .vbus_vld(vbus_vld), .dir(dir), .nxt(nxt),
      .data_o(data_o), .data_oe(data_oe), .phy_ready(phy_ready),
      .lp_exit(lp_exit), .tx_active(tx_active), .rx_active(rx_active),
      .rx_error(rx_error), .host_disc(host_disc), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_take(rx_take), .acc_event(acc_event));

   urxg_link_model link (.link_clk(link_clk), .stp(stp), .stp_req(stp_req),
      .dir(dir), .nxt(nxt), .data_o(data_o), .data_oe(data_oe),
      .last_cmd(last_cmd), .last_byte(last_byte), .cmd_cnt(cmd_cnt),
      .rx_start_seen(rx_start_seen), .turn_bad(turn_bad));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task conclude;
      if (miscompares == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Hang guard, and the byte source drops its request once taken
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (rx_take === 1'b1) rx_valid <= 1'b0;
      if (cycles == 20000) begin
         miscompares++;
         conclude;
      end
   end

   function automatic logic [7:0] exp_cmd(input logic alt);
      logic [1:0] vb, ev;
      vb = vbus_vld ? 2'h3 : sess_vld ? 2'h2 : sess_end ? 2'h0 : 2'h1;
      ev = host_disc ? 2'h2 : (rx_active && rx_error) ? 2'h3 :
         rx_active ? 2'h1 : 2'h0;
      return {alt, id_pin, ev, vb, dm, dp};
   endfunction

   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Only pready or the bench timeout ends a wait for the slave
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e);
   endtask

   task settle;
      repeat (150) @(posedge clk);
   endtask

   // New command seen since c0, carrying the present pin state
   task expect_cmd(input logic alt);
      settle;
      check({31'h0, cmd_cnt > c0}, 32'h1);
      check({24'h0, last_cmd}, {24'h0, exp_cmd(alt)});
   endtask

   task no_cmd;
      settle;
      check({31'h0, cmd_cnt == c0}, 32'h1);
   endtask

   task stp_pulse;
      stp_req <= 1'b1;
      repeat (16) @(posedge clk);
      stp_req <= 1'b0;
   endtask

   task kick;
      c0 = cmd_cnt;
      dp <= ~dp;
   endtask

   initial begin
      seed = 33198;
      {cycles, miscompares, total_checks} = '0;
      {nrst, psel, penable, pwrite, paddr, pwdata, stp_req} = '0;
      {dm, sess_end, phy_ready, lp_exit, tx_active, rx_active} = '0;
      {rx_error, host_disc, rx_valid, rx_data, acc_event} = '0;
      {dp, id_pin, sess_vld, vbus_vld} = 4'hF;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check({31'h0, data_oe}, 32'h0);
      check({31'h0, dir}, 32'h1);
      rchk(12'h000, 32'h1);
      rchk(12'h00C, 32'h0);
      rchk(12'h014, 32'hF);
      rchk(12'h020, 32'h0);
      check({31'h0, er}, 32'h1);
      settle;
      check({31'h0, dir}, 32'h1);
      c0 = cmd_cnt;
      phy_ready <= 1'b1;
      expect_cmd(1'b0);
      for (i = 0; i < 12; i++) begin
         b = $random(seed);
         kick;
         vbus_vld <= b[1:0] == 2'h3;
         sess_vld <= b[1];
         sess_end <= b[1] ? b[5] : b[1:0] == 2'h0;
         id_pin <= b[2];
         dm <= b[3];
         expect_cmd(1'b0);
      end
      c0 = cmd_cnt;
      id_pin <= ~id_pin;
      expect_cmd(1'b0);
      apb(1'b1, 12'h000, 32'h0);
      kick;
      no_cmd;
      apb(1'b1, 12'h000, 32'h1);
      tx_active <= 1'b1;
      settle;
      kick;
      no_cmd;
      stp_pulse;
      tx_active <= 1'b0;
      expect_cmd(1'b0);
      stp_pulse;
      c0 = cmd_cnt;
      lp_exit <= 1'b1;
      @(posedge clk);
      lp_exit <= 1'b0;
      expect_cmd(1'b0);
      for (i = 0; i < 3; i++) begin
         kick;
         {rx_active, rx_error, host_disc} <= ev_tab[i];
         expect_cmd(1'b0);
         if (i == 0) begin
            check({31'h0, cmd_cnt - c0 > 8}, 32'h1);
            check({31'h0, rx_start_seen}, 32'h1);
            b = $random(seed);
            rx_data <= b[7:0];
            rx_valid <= 1'b1;
            settle;
            check({24'h0, last_byte}, {24'h0, b[7:0]});
         end
      end
      // Event bits alone are no trigger, so a line change carries them
      kick;
      host_disc <= 1'b0;
      expect_cmd(1'b0);
      kick;
      acc_event <= 4'h4;
      @(posedge clk);
      acc_event <= 4'h0;
      expect_cmd(1'b1);
      if (last_cmd[7] === 1'b1) rchk(12'h010, 32'h4);
      apb(1'b1, 12'h010, 32'h4);
      kick;
      expect_cmd(1'b0);
      apb(1'b1, 12'h014, 32'h0);
      kick;
      acc_event <= 4'h1;
      @(posedge clk);
      acc_event <= 4'h0;
      expect_cmd(1'b0);
      apb(1'b1, 12'h014, 32'hF);
      apb(1'b1, 12'h010, 32'hF);
      apb(1'b1, 12'h008, 32'h7);
      rchk(12'h008, 32'h0);
      kick;
      settle;
      rchk(12'h008, 32'h1);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, 12'h00C, 32'h1);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, 12'h008, 32'h1);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      check({31'h0, turn_bad}, 32'h0);
      conclude;
   end
endmodule
